//--- common/brg_pkg.sv
// constants shared by the serial rate generator and its leaves
// assumes one 40 MHz system clock standing in for the oscillator
`default_nettype none
package brg_pkg;
   // register addresses on the byte register port
   localparam logic [7:0] RX_CTRL_ADDR = 8'h18;
   localparam logic [7:0] TX_CTRL_ADDR = 8'h98;
   localparam logic [7:0] DIVISOR_ADDR = 8'h99;
   // transmit_status_control field positions
   localparam int TX_CLK_SRC_BIT = 7;
   localparam int TX_SYNC_BIT    = 4;
   localparam int TX_UNUSED_BIT  = 3;
   localparam int TX_HIGH_SPD_BIT = 2;
   localparam int TX_EMPTY_BIT   = 1;
   // receive_status_control: low three bits come from the receiver
   localparam int RX_STATUS_W    = 3;
   // reset values
   localparam logic [7:0] RX_CTRL_RST  = 8'h00;
   localparam logic [7:0] TX_CTRL_RST  = 8'h02;
   localparam logic [7:0] DIVISOR_RST  = 8'h00;
   // bits software may write
   localparam logic [7:0] TX_WR_MASK   = 8'hf5;
   localparam logic [7:0] RX_WR_MASK   = 8'hf8;
   // division ratios, divisor width and vote sample count
   localparam int QUARTER_DIV   = 4;
   localparam int POST_LOW_DIV  = 16;
   localparam int POST_HIGH_DIV = 4;
   localparam int RATE_W        = 8;
   localparam int VOTE_SAMPLES  = 3;
   // operating mode of the serial port
   typedef enum logic {MODE_ASYNC, MODE_SYNC} rate_mode_t;
endpackage : brg_pkg
`default_nettype wire

//--- common/brg_if.sv
// link between rate generator control and its reloadable timer
// assumes both ends share clock_i
`default_nettype none
interface brg_if #(parameter int W = 8);
   logic [W-1:0] divisor;   // reload value X
   logic         clear;     // restart count at zero
   logic         enable;    // quarter-rate count enable
   logic         tick;      // one-cycle overflow pulse
   logic [W-1:0] count;     // present count
   modport timer (input divisor, clear, enable, output tick, count);
   modport ctrl  (output divisor, clear, enable, input tick, count);
endinterface : brg_if
`default_nettype wire

//--- hw/rate_timer.sv
// free running reloadable rate timer, one tick every X+1 enables
// assumes enable and clear come from logic on clock_i
`default_nettype none
module rate_timer (
   input  wire logic clock_i,   // system clock
   input  wire logic rst_b_i,   // async reset, active low
   brg_if.timer      t          // control and tick
);
   logic [7:0] cnt_q, cnt_d;
   logic       tick_q, tick_d;
   logic       wrap;

   // count wraps when it meets the divisor
   assign wrap   = t.enable & (cnt_q == t.divisor);         // [RQ2]
   assign cnt_d  = t.clear ? 8'h00 :                        // [RQ10]
                   wrap    ? 8'h00 :
                   t.enable ? cnt_q + 8'h01 : cnt_q;
   assign tick_d = wrap & ~t.clear;                         // [RQ3]
   assign t.tick  = tick_q;
   assign t.count = cnt_q;

   // state registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   property p_period;
      @(posedge clock_i) disable iff (!rst_b_i)
      tick_q |-> $past(cnt_q) == $past(t.divisor);
   endproperty
   a_period: assert property (p_period) // [RQ3]
      else $error("timer ticked away from divisor");
endmodule : rate_timer
`default_nettype wire

//--- hw/rx_majority.sv
// three sample majority vote on the synchronised receive pin
// assumes pin_i is already in the clock_i domain
`default_nettype none
module rx_majority (
   input  wire logic clock_i,   // system clock
   input  wire logic rst_b_i,   // async reset, active low
   input  wire logic sample_i,  // take a sample this cycle
   input  wire logic pin_i,     // synchronised pin level
   output logic      level_o    // voted level
);
   logic [2:0] smp_q;
   logic       maj;

   // two of three decide; idle line reset high
   assign maj = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) |
                (smp_q[0] & smp_q[2]);                      // [RQ11]

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         smp_q   <= 3'h7;
         level_o <= 1'b1;
      end else begin
         if (sample_i) smp_q <= {smp_q[1:0], pin_i};
         level_o <= maj;
      end
   end

   property p_vote;
      @(posedge clock_i) disable iff (!rst_b_i)
      (smp_q inside {3'h3, 3'h5, 3'h6, 3'h7}) |=> level_o;
   endproperty
   a_vote: assert property (p_vote) // [RQ11]
      else $error("majority of ones not reported high");
endmodule : rx_majority
`default_nettype wire

//--- hw/rate_generator_top.sv
// serial port rate generator with receive pin sampler
// assumes a byte register port on clock_i and async transmit/receive
// neighbours that consume the ticks on the same clock
//
// Function
// [RQ1] one dedicated 8-bit generator serves async and sync modes
// [RQ2] divisor sets period of a free running 8-bit timer
// [RQ3] any divisor 0..255 accepted; divide term is X+1
// [RQ4] async low speed bit rate is clock / (64*(X+1))
// [RQ5] async high speed bit rate is clock / (16*(X+1))
// [RQ6] sync bit rate is clock / (4*(X+1))
// [RQ7] speed select sits at bit 2 of transmit control
// [RQ8] sync mode ignores speed select completely
// [RQ9] rates only generated as master with internal clock
// [RQ10] writing the divisor clears the timer at once
// [RQ11] receive pin decided by two of three samples
// [RQ12] software may prefer high speed for lower rate error
// [RQ13] transmit control bit 3 reads back zero
// [RQ14] sync bit, bit 4 of transmit control, selects mode
// [RQ15] async output runs 16 or 64 times the bit rate; rate_tick_o here runs 16 (low speed) or 4 (high speed) times
// [RQ16] timer counts at quarter clock, ticks every X+1 counts
// [RQ17] sync slave mode does not shift on generator ticks
//
// Our own choice: the address-and-strobe port.
`default_nettype none
module rate_generator_top
   import brg_pkg::*;
#(
   parameter int DIV_W = brg_pkg::RATE_W  // divisor width
) (
   input  wire logic        clock_i,      // 40 MHz system clock
   input  wire logic        rst_b_i,      // async reset, active low
   input  wire logic [7:0]  addr_i,       // register address
   input  wire logic [7:0]  wr_data_i,    // register write data
   input  wire logic        wr_i,         // write strobe
   input  wire logic        rd_i,         // read strobe
   output logic      [7:0]  rd_data_o,    // read data, cycle after rd_i
   input  wire logic        tx_empty_i,   // transmit shifter empty
   input  wire logic [2:0]  rx_status_i,  // receiver status bits
   input  wire logic        rx_pin_i,     // receive data pin
   output logic             rate_tick_o,  // oversample tick pulse
   output logic             bit_tick_o,   // bit shift tick pulse
   output logic             rx_level_o,   // voted receive level
   output logic      [7:0]  tx_ctrl_o,    // transmit control bits
   output logic      [7:0]  rx_ctrl_o     // receive control bits
);
   import brg_pkg::*;

   // the timer and its width checks are fixed at eight bits
   if (DIV_W != RATE_W) begin : g_bad_width
      $error("rate divisor width must be eight");
   end

   brg_if #(.W(DIV_W)) tif ();

   // register storage
   logic [7:0] tx_ctrl_q, tx_ctrl_d;
   logic [7:0] rx_ctrl_q, rx_ctrl_d;
   logic [7:0] divisor_q, divisor_d;
   logic [7:0] rd_data_d;

   // address decode
   logic sel_tx, sel_rx, sel_div;
   logic wr_tx, wr_rx, wr_div;
   assign sel_tx  = (addr_i == TX_CTRL_ADDR);
   assign sel_rx  = (addr_i == RX_CTRL_ADDR);
   assign sel_div = (addr_i == DIVISOR_ADDR);
   assign wr_tx   = wr_i & sel_tx;
   assign wr_rx   = wr_i & sel_rx;
   assign wr_div  = wr_i & sel_div;

   // only writable fields take the data; the rest keep their value
   assign tx_ctrl_d = wr_tx ?
      ((wr_data_i & TX_WR_MASK) | (tx_ctrl_q & ~TX_WR_MASK)) :
      tx_ctrl_q;
   assign rx_ctrl_d = wr_rx ?
      ((wr_data_i & RX_WR_MASK) | (rx_ctrl_q & ~RX_WR_MASK)) :
      rx_ctrl_q;
   assign divisor_d = wr_div ? wr_data_i : divisor_q;       // [RQ3]

   // read views: live status merged over stored control bits
   logic [7:0] tx_view, rx_view;
   always_comb begin
      tx_view = tx_ctrl_q & TX_WR_MASK;
      tx_view[TX_UNUSED_BIT] = 1'b0;                        // [RQ13]
      tx_view[TX_EMPTY_BIT]  = tx_empty_i;
      rx_view = rx_ctrl_q & RX_WR_MASK;
      rx_view[RX_STATUS_W-1:0] = rx_status_i;
   end

   // unmapped addresses read zero; data only in the cycle after rd_i
   assign rd_data_d = !rd_i   ? 8'h00 :
                      sel_tx  ? tx_view :
                      sel_rx  ? rx_view :
                      sel_div ? divisor_q : 8'h00;

   // register file
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_ctrl_q <= TX_CTRL_RST;
         rx_ctrl_q <= RX_CTRL_RST;
         divisor_q <= DIVISOR_RST;
         rd_data_o <= 8'h00;
      end else begin
         tx_ctrl_q <= tx_ctrl_d;
         rx_ctrl_q <= rx_ctrl_d;
         divisor_q <= divisor_d;
         rd_data_o <= rd_data_d;
      end
   end

   // mode decode from transmit control
   rate_mode_t mode;
   logic       high_speed_select;
   logic       clock_source_select;
   logic       master;
   assign mode = tx_ctrl_q[TX_SYNC_BIT] ? MODE_SYNC : MODE_ASYNC; // [RQ14]
   // speed select only matters in async mode
   assign high_speed_select = (mode == MODE_ASYNC) &
                              tx_ctrl_q[TX_HIGH_SPD_BIT];   // [RQ7] [RQ8]
   assign clock_source_select = tx_ctrl_q[TX_CLK_SRC_BIT];
   // async always uses the internal rate; sync only as clock master
   assign master = (mode == MODE_ASYNC) | clock_source_select; // [RQ9]

   // quarter-clock enable feeding the timer
   logic [1:0] quarter_q, quarter_d;
   logic       quarter_en;
   assign quarter_en = (quarter_q == 2'(QUARTER_DIV - 1));  // [RQ16]
   // a divisor write restarts the whole chain so the new rate starts clean
   assign quarter_d  = (wr_div | quarter_en) ? 2'h0 : quarter_q + 2'h1;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) quarter_q <= 2'h0;
      else          quarter_q <= quarter_d;
   end

   // one shared timer serves every mode
   assign tif.divisor = divisor_q;                          // [RQ1] [RQ2]
   assign tif.clear   = wr_div;                             // [RQ10]
   assign tif.enable  = quarter_en;

   rate_timer u_timer (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .t       (tif.timer)
   );

   // post divider: 16 for low speed, 4 for high speed, async only
   logic [3:0] post_q, post_d;
   logic [3:0] post_last;
   logic       post_hit;
   assign post_last = high_speed_select ? 4'(POST_HIGH_DIV - 1)
                                        : 4'(POST_LOW_DIV - 1); // [RQ4] [RQ5]
   assign post_hit  = tif.tick & (post_q >= post_last);
   assign post_d    = wr_div   ? 4'h0 :
                      post_hit ? 4'h0 :
                      tif.tick ? post_q + 4'h1 : post_q;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) post_q <= 4'h0;
      else          post_q <= post_d;
   end

   // tick outputs: the timer tick is the oversample clock, the bit tick
   // is the post divided one in async and the timer tick itself in sync
   logic rate_tick_d, bit_tick_d;
   assign rate_tick_d = tif.tick & master;                  // [RQ15]
   assign bit_tick_d  = master & ((mode == MODE_SYNC) ? tif.tick
                                                     : post_hit); // [RQ6] [RQ17]

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rate_tick_o <= 1'b0;
         bit_tick_o  <= 1'b0;
         tx_ctrl_o   <= TX_CTRL_RST & TX_WR_MASK;
         rx_ctrl_o   <= RX_CTRL_RST & RX_WR_MASK;
      end else begin
         rate_tick_o <= rate_tick_d;
         bit_tick_o  <= bit_tick_d;
         tx_ctrl_o   <= tx_ctrl_q & TX_WR_MASK;
         rx_ctrl_o   <= rx_ctrl_q & RX_WR_MASK;
      end
   end

   // receive pin crosses in through two flops before the vote
   logic rx_meta_q, rx_sync_q;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin_i;
         rx_sync_q <= rx_meta_q;
      end
   end

   // samples are taken at the quarter rate, fast against any async bit time
   rx_majority u_vote (
      .clock_i  (clock_i),
      .rst_b_i  (rst_b_i),
      .sample_i (quarter_en),                               // [RQ11]
      .pin_i    (rx_sync_q),
      .level_o  (rx_level_o)
   );

   // checks

   property p_div_clear;
      @(posedge clock_i) disable iff (!rst_b_i)
      wr_div |=> (tif.count == 8'h00) && !tif.tick;
   endproperty
   a_div_clear: assert property (p_div_clear) // [RQ10]
      else $error("divisor write did not clear timer");

   property p_bit3_zero;
      @(posedge clock_i) disable iff (!rst_b_i)
      (rd_i && sel_tx) |=> (rd_data_o[TX_UNUSED_BIT] == 1'b0);
   endproperty
   a_bit3_zero: assert property (p_bit3_zero) // [RQ13]
      else $error("unused transmit control bit read as one");

   property p_slave_quiet;
      @(posedge clock_i) disable iff (!rst_b_i)
      (tx_ctrl_q[TX_SYNC_BIT] && !tx_ctrl_q[TX_CLK_SRC_BIT])
         |=> !bit_tick_o && !rate_tick_o;
   endproperty
   a_slave_quiet: assert property (p_slave_quiet) // [RQ17] [RQ9]
      else $error("tick in sync slave mode");

   property p_sync_rate;
      @(posedge clock_i) disable iff (!rst_b_i)
      (tx_ctrl_q[TX_SYNC_BIT] && tx_ctrl_q[TX_CLK_SRC_BIT] && tif.tick)
         |=> bit_tick_o;
   endproperty
   a_sync_rate: assert property (p_sync_rate) // [RQ6] [RQ8]
      else $error("sync bit tick missing");

   property p_async_low;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!tx_ctrl_q[TX_SYNC_BIT] && !tx_ctrl_q[TX_HIGH_SPD_BIT] &&
       tif.tick && post_q == 4'hf) |=> bit_tick_o;
   endproperty
   a_async_low: assert property (p_async_low) // [RQ4]
      else $error("low speed bit tick missing");

   property p_async_high;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!tx_ctrl_q[TX_SYNC_BIT] && tx_ctrl_q[TX_HIGH_SPD_BIT] &&
       tif.tick && post_q == 4'h3) |=> bit_tick_o;
   endproperty
   a_async_high: assert property (p_async_high) // [RQ5]
      else $error("high speed bit tick missing");

   property p_bit_from_timer;
      @(posedge clock_i) disable iff (!rst_b_i)
      bit_tick_o |-> $past(tif.tick);
   endproperty
   a_bit_from_timer: assert property (p_bit_from_timer) // [RQ2]
      else $error("bit tick without timer overflow");

   property p_quarter;
      @(posedge clock_i) disable iff (!rst_b_i)
      (quarter_en && !wr_div) |=> !quarter_en [*3];
   endproperty
   a_quarter: assert property (p_quarter) // [RQ16]
      else $error("quarter enable too frequent");

   property p_async_spacing;
      @(posedge clock_i) disable iff (!rst_b_i)
      (bit_tick_o && !tx_ctrl_q[TX_SYNC_BIT]) |=> !bit_tick_o [*8];
   endproperty
   a_async_spacing: assert property (p_async_spacing) // [RQ15]
      else $error("async bit ticks too close");

   // register port: a divisor write lands whole and reads back next cycle
   property p_div_write;
      @(posedge clock_i) disable iff (!rst_b_i)
      wr_div |=> (divisor_q == $past(wr_data_i));
   endproperty
   a_div_write: assert property (p_div_write) // [RQ3]
      else $error("divisor write did not land");

   property p_div_read;
      @(posedge clock_i) disable iff (!rst_b_i)
      (rd_i && sel_div) |=> (rd_data_o == $past(divisor_q));
   endproperty
   a_div_read: assert property (p_div_read) // [RQ3]
      else $error("divisor read back wrong");

   // the mode bit reaches the neighbours two edges after the write
   property p_mode_out;
      @(posedge clock_i) disable iff (!rst_b_i)
      wr_tx |=> ##1 (tx_ctrl_o[TX_SYNC_BIT] ==
                     $past(wr_data_i[TX_SYNC_BIT], 2));
   endproperty
   a_mode_out: assert property (p_mode_out) // [RQ14]
      else $error("sync mode bit not passed on");

   property p_rate_master;
      @(posedge clock_i) disable iff (!rst_b_i)
      rate_tick_o |-> ($past(tif.tick) && $past(master));
   endproperty
   a_rate_master: assert property (p_rate_master) // [RQ9]
      else $error("rate tick while not clock master");

   // the timer cannot tick faster than the quarter clock allows
   property p_timer_gap;
      @(posedge clock_i) disable iff (!rst_b_i)
      tif.tick |=> !tif.tick [*3];
   endproperty
   a_timer_gap: assert property (p_timer_gap) // [RQ16]
      else $error("timer ticks closer than four clocks");

   property p_sync_same;
      @(posedge clock_i) disable iff (!rst_b_i)
      (tx_ctrl_q[TX_SYNC_BIT] && tx_ctrl_q[TX_CLK_SRC_BIT])
         |=> (bit_tick_o == rate_tick_o);
   endproperty
   a_sync_same: assert property (p_sync_same) // [RQ8]
      else $error("sync bit tick depends on speed select");

   property p_sync_idle;
      @(posedge clock_i) disable iff (!rst_b_i)
      (tx_ctrl_q[TX_SYNC_BIT] && tx_ctrl_q[TX_CLK_SRC_BIT] && !tif.tick)
         |=> !bit_tick_o;
   endproperty
   a_sync_idle: assert property (p_sync_idle) // [RQ6]
      else $error("sync bit tick without timer tick");

   property p_low_gap;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!tx_ctrl_q[TX_SYNC_BIT] && !tx_ctrl_q[TX_HIGH_SPD_BIT] &&
       tif.tick && post_q != 4'hf) |=> !bit_tick_o;
   endproperty
   a_low_gap: assert property (p_low_gap) // [RQ4]
      else $error("low speed bit tick too early");

   property p_high_gap;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!tx_ctrl_q[TX_SYNC_BIT] && tx_ctrl_q[TX_HIGH_SPD_BIT] &&
       tif.tick && post_q < 4'h3) |=> !bit_tick_o;
   endproperty
   a_high_gap: assert property (p_high_gap) // [RQ5]
      else $error("high speed bit tick too early");
endmodule : rate_generator_top
`default_nettype wire

//--- verif/serial_far_model.sv
// behavioural shift logic that consumes the rate and bit ticks
// assumes one-cycle tick pulses on clock_i; measures tick spacing
`default_nettype none
module serial_far_model (
   input  wire logic        clock_i,       // system clock
   input  wire logic        rst_b_i,       // async reset, active low
   input  wire logic        bit_tick_i,    // bit shift tick
   input  wire logic        rate_tick_i,   // oversample tick
   input  wire logic        send_i,        // start an eight bit frame
   output logic             tx_empty_o,    // shifter idle
   output logic      [2:0]  rx_status_o,   // looped frames, wraps
   output logic      [15:0] bit_period_o,  // clocks between bit ticks
   output logic      [15:0] rate_period_o, // clocks between rate ticks
   output logic      [15:0] bit_cnt_o      // bit ticks seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] bit_gap_q;   // clocks since last bit tick
   logic [15:0] rate_gap_q;  // clocks since last rate tick
   logic [3:0]  left_q;      // bits still to shift
   assign tx_empty_o = (left_q == 4'h0);
   // shifting moves only on bit ticks, never on the oversample tick
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_gap_q     <= 16'h0000;
         rate_gap_q    <= 16'h0000;
         left_q        <= 4'h0;
         rx_status_o   <= 3'h0;
         bit_period_o  <= 16'h0000;
         rate_period_o <= 16'h0000;
         bit_cnt_o     <= 16'h0000;
      end else begin
         bit_gap_q  <= bit_tick_i ? 16'h0000 : bit_gap_q + 16'h0001;
         rate_gap_q <= rate_tick_i ? 16'h0000 : rate_gap_q + 16'h0001;
         if (bit_tick_i) begin
            bit_period_o <= bit_gap_q + 16'h0001;
            bit_cnt_o    <= bit_cnt_o + 16'h0001;
         end
         if (rate_tick_i) begin
            rate_period_o <= rate_gap_q + 16'h0001;
         end
         // a finished frame is looped back as a received one
         if (send_i && tx_empty_o) begin
            left_q <= 4'h8;
         end else if (bit_tick_i && !tx_empty_o) begin
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
               rx_status_o <= rx_status_o + 3'h1;
            end
         end
      end
   end
endmodule : serial_far_model
`default_nettype wire

//--- verif/rate_generator_top_tb_top.sv
// self-checking bench for the serial rate generator
// assumes the far-side model drives the shifter status inputs
`default_nettype none
`define CHK(nm, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
   end \
end
module rate_generator_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import brg_pkg::*;
   logic        clock_i, rst_b_i, wr_i, rd_i, rx_pin_i, send;
   logic [7:0]  addr_i, wr_data_i, rd_data_o, tx_ctrl_o, rx_ctrl_o;
   logic        rate_tick_o, bit_tick_o, rx_level_o, tx_empty;
   logic [2:0]  rx_status;
   logic [15:0] bit_period, rate_period, bit_cnt;
   int          err_total, samples_checked, cycles;

   rate_generator_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .tx_empty_i(tx_empty),
      .rx_status_i(rx_status), .rx_pin_i(rx_pin_i),
      .rate_tick_o(rate_tick_o), .bit_tick_o(bit_tick_o),
      .rx_level_o(rx_level_o), .tx_ctrl_o(tx_ctrl_o),
      .rx_ctrl_o(rx_ctrl_o));
   serial_far_model far (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .bit_tick_i(bit_tick_o), .rate_tick_i(rate_tick_o), .send_i(send),
      .tx_empty_o(tx_empty), .rx_status_o(rx_status),
      .bit_period_o(bit_period), .rate_period_o(rate_period),
      .bit_cnt_o(bit_cnt));

   // 40 MHz clock
   always #12.5 clock_i = ~clock_i;

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // a hang stops well beyond the longest expected run
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         $display("timeout after %0d cycles", cycles);
         final_report();
      end
   end

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= 1'b1;
      @(posedge clock_i);
      wr_i      <= 1'b0;
   endtask : reg_wr

   // read data stand only in the cycle after the strobe
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
                         input string nm);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i   <= 1'b0;
      #1;
      `CHK(nm, e, rd_data_o)
   endtask : chk_rd

   // bounded wait so a dead generator cannot hang the run
   task automatic wait_bits(input int n);
      logic [15:0] s;
      int i;
      s = bit_cnt;
      for (i = 0; i < 20000 && int'(bit_cnt - s) < n; i++)
         @(posedge clock_i);
   endtask : wait_bits

   task automatic watch(input int n, input logic lvl, output logic seen);
      int i;
      seen = 1'b0;
      for (i = 0; i < n; i++) begin
         @(posedge clock_i);
         #1;
         seen = seen | (lvl ? (rate_tick_o | bit_tick_o) : rx_level_o);
      end
   endtask : watch

   task automatic t_regs();
      chk_rd(TX_CTRL_ADDR, 8'h02, "tx_reset");
      chk_rd(RX_CTRL_ADDR, 8'h00, "rx_reset");
      chk_rd(DIVISOR_ADDR, 8'h00, "div_reset");
      reg_wr(TX_CTRL_ADDR, 8'hff);
      chk_rd(TX_CTRL_ADDR, 8'hf7, "tx_rw");
      `CHK("tx_ctrl_o", 8'hf5, tx_ctrl_o)
      reg_wr(RX_CTRL_ADDR, 8'hff);
      chk_rd(RX_CTRL_ADDR, {5'h1f, rx_status}, "rx_rw");
      `CHK("rx_ctrl_o", 8'hf8, rx_ctrl_o)
      reg_wr(DIVISOR_ADDR, 8'ha5);
      chk_rd(DIVISOR_ADDR, 8'ha5, "div_rw");
      reg_wr(8'h55, 8'hff);
      chk_rd(8'h55, 8'h00, "unmapped");
      $display("test regs done");
   endtask : t_regs

   task automatic t_rate(input logic [7:0] c, input logic [7:0] x,
                         input logic [15:0] bp, input logic [15:0] rp);
      reg_wr(TX_CTRL_ADDR, c);
      reg_wr(DIVISOR_ADDR, x);
      wait_bits(3);
      `CHK("bit_period", bp, bit_period)
      `CHK("rate_period", rp, rate_period)
      chk_rd(TX_CTRL_ADDR, (c & TX_WR_MASK) | 8'h02, "tx_mode");
      $display("test rate %h %h done", c, x);
   endtask : t_rate

   task automatic t_clear();
      logic seen;
      reg_wr(TX_CTRL_ADDR, 8'h90);
      reg_wr(DIVISOR_ADDR, 8'hff);
      repeat (100) @(posedge clock_i);
      reg_wr(DIVISOR_ADDR, 8'h00);
      watch(8, 1'b1, seen);
      `CHK("tick_after_clear", 1'b1, seen)
      $display("test clear done");
   endtask : t_clear

   task automatic t_slave();
      logic seen;
      reg_wr(TX_CTRL_ADDR, 8'h10);
      reg_wr(DIVISOR_ADDR, 8'h00);
      watch(200, 1'b1, seen);
      `CHK("slave_ticks", 1'b0, seen)
      $display("test slave done");
   endtask : t_slave

   task automatic t_empty();
      reg_wr(TX_CTRL_ADDR, 8'h90);
      reg_wr(DIVISOR_ADDR, 8'h00);
      send <= 1'b1;
      @(posedge clock_i);
      send <= 1'b0;
      chk_rd(TX_CTRL_ADDR, 8'h90, "tx_busy");
      wait_bits(10);
      chk_rd(TX_CTRL_ADDR, 8'h92, "tx_idle");
      chk_rd(RX_CTRL_ADDR, 8'hf9, "rx_status");
      $display("test empty done");
   endtask : t_empty

   // a two-cycle spike can reach at most one of the three samples
   task automatic t_vote();
      logic seen;
      @(posedge clock_i);
      rx_pin_i <= 1'b0;
      watch(24, 1'b0, seen);
      `CHK("level_low", 1'b0, rx_level_o)
      rx_pin_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      rx_pin_i <= 1'b0;
      watch(24, 1'b0, seen);
      `CHK("spike", 1'b0, seen)
      @(posedge clock_i);
      rx_pin_i <= 1'b1;
      watch(24, 1'b0, seen);
      `CHK("level_high", 1'b1, rx_level_o)
      $display("test vote done");
   endtask : t_vote

   initial begin
      clock_i   = 1'b0;
      rst_b_i   = 1'b0;
      addr_i    = 8'h00;
      wr_data_i = 8'h00;
      wr_i      = 1'b0;
      rd_i      = 1'b0;
      rx_pin_i  = 1'b1;
      send      = 1'b0;
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_rate(8'h00, 8'h02, 16'h00c0, 16'h000c);
      t_rate(8'h04, 8'h02, 16'h0030, 16'h000c);
      t_rate(8'h90, 8'h03, 16'h0010, 16'h0010);
      t_rate(8'h94, 8'h03, 16'h0010, 16'h0010);
      t_rate(8'h90, 8'h00, 16'h0004, 16'h0004);
      t_rate(8'h04, 8'hff, 16'h1000, 16'h0400);
      t_clear();
      t_slave();
      t_empty();
      t_vote();
      final_report();
   end
endmodule : rate_generator_top_tb_top
`undef CHK
`default_nettype wire
